// [design/msp_fifo.sv]
// Purpose: Small synchronous FIFO with valid and ready on both sides.
// Assumes: One clock domain.
// Notes: Depth must be a power of two.
`timescale 1ns/1ps
`default_nettype none
module msp_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned D = 8
) (
  input wire logic clk_sys, // System clock.
  input wire logic rst_n, // Asynchronous reset.
  input wire logic in_valid, // Write request.
  output logic in_ready, // Not full.
  input wire logic [W-1:0] in_data, // Write word.
  output logic out_valid, // Not empty.
  input wire logic out_ready, // Read acknowledge.
  output logic [W-1:0] out_data // Head word.
);
  localparam int unsigned AW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [AW:0] wp_q;
  logic [AW:0] rp_q;
  assign in_ready = (wp_q - rp_q) != (AW+1)'(D);
  assign out_valid = wp_q != rp_q;
  assign out_data = mem_q[rp_q[AW-1:0]];
  always_ff @(posedge clk_sys) begin
    if (in_valid && in_ready) begin
      mem_q[wp_q[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (in_valid && in_ready) begin
        wp_q <= wp_q + 1'b1;
      end
      if (out_valid && out_ready) begin
        rp_q <= rp_q + 1'b1;
      end
    end
  end
endmodule : msp_fifo
`default_nettype wire

// [design/msp_pkg.sv]
// Purpose: Shared constants and carriers for the MAC serial pin interface.
// Assumes: System clock of 100 MHz.
// Notes: Offsets of the plain register port are chosen locally.
package msp_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned BIT_NS = 100;
  localparam int unsigned BIT_CYC = (BIT_NS * CLK_MHZ) / 1000;
  localparam int unsigned CRS_HOLD_HALF_BITS = 3;
  localparam int unsigned CRS_HOLD_CYC = (CRS_HOLD_HALF_BITS * BIT_CYC + 1) / 2;
  localparam int unsigned RXC_TAIL_BITS = 5;
  localparam int unsigned RXC_TAIL_CYC = RXC_TAIL_BITS * BIT_CYC;
  localparam int unsigned OSC_DIV = 2;
  localparam logic [3:0] ADDR_DCR = 4'h0;
  localparam logic [3:0] ADDR_DATA_CONFIG_REGISTER_TWO = 4'h1;
  localparam logic [3:0] ADDR_CTRL = 4'h2;
  localparam logic [3:0] ADDR_STAT = 4'h3;
  localparam int unsigned DCR_EXTENDED_BUS_SETTING_BIT = 0;
  localparam int unsigned CTRL_LBK_BIT = 0;
  localparam int unsigned CTRL_EXT_BIT = 1;
  localparam logic [15:0] DCR_RST = 16'h0000;
  localparam logic [15:0] DATA_CONFIG_REGISTER_TWO_RST = 16'h0000;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam int unsigned FIFO_W = 8;
  localparam int unsigned FIFO_D = 8;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } msp_reg_req_s;

  typedef struct packed {
    logic o;
    logic oe;
  } msp_pin_s;

  typedef enum logic [1:0] {
    MSP_TX_IDLE,
    MSP_TX_SHIFT,
    MSP_TX_LAST
  } msp_tx_e;
endpackage : msp_pkg

// [design/msp_top.sv]
// Purpose: MAC serial pin interface with internal or external coder and user outputs.
// Assumes: Pins from outside pass three flip-flops; link clocks are sampled by clk_sys.
// Notes: The internal coder clocks are modelled as strobes and pins on clk_sys.
// Contract
// - Recovered receive clock runs five bit times after carrier sense drops.
// - Multiplexed pins float after reset until the first data config write.
// - Extended bus setting turns three pins into user outputs.
// - User outputs float until first bus mastership, then drive config two levels.
// - Transmit data valid at rising edge of the transmit clock.
// - Transmit active flag high from frame start until last byte sent.
// - Internal coder: 10 MHz transmit clock from 20 MHz oscillator, driven on pin.
// - External coder: serializer shifts on the supplied transmit clock.
// - Bus master samples sync termination synchronously, only in asynchronous mode.
// - Loopback indicator high when coder loopback programmed, else low.
// - Carrier sense on first falling receive edge, holds 1.5 bits after last.
// - External coder: receive data captured on rising external receive clock.
`timescale 1ns/1ps
`default_nettype none
module msp_top (
  input wire logic clk_sys, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic [3:0] reg_addr, // Register address.
  input wire logic [15:0] reg_wdata, // Register write data.
  input wire logic reg_wr, // Write strobe.
  input wire logic reg_rd, // Read strobe.
  output logic [15:0] reg_rdata, // Read data, cycle after strobe.
  input wire logic osc_in, // 20 MHz oscillator pin.
  input wire logic line_rx_in, // Internal decoder receive line.
  input wire logic external_coder_select, // High selects external coder.
  input wire logic bus_mode_pin, // High selects asynchronous bus mode.
  input wire logic bus_master, // Device currently owns the bus.
  input wire logic mem_cycle_end_req, // Memory cycle ready to end.
  output logic mem_cycle_done, // Memory cycle terminated.
  input wire logic tx_valid, // MAC transmit byte valid.
  output logic tx_ready, // Transmit FIFO can accept.
  input wire logic [7:0] tx_byte, // MAC transmit byte.
  output logic rx_bit_valid, // Received NRZ bit strobe.
  output logic rx_bit, // Received NRZ bit.
  output logic carrier_sense_out, // Internal decoder carrier sense.
  output logic tx_active_flag, // Transmit enable pin.
  output logic tx_data_o, // Transmit data or user output three.
  output logic tx_data_oe, // Enable of that pin.
  input wire logic external_rx_bit_in, // External decoded receive data.
  output logic rx_clk_o, // Recovered clock or user output two.
  output logic rx_clk_oe, // Enable of that pin.
  input wire logic external_rx_clock_in, // Receive clock pin input side.
  output logic tx_clk_o, // Internal transmit clock out.
  output logic tx_clk_oe, // Enable of that pin.
  input wire logic external_tx_clock_in, // Transmit clock pin input side.
  output logic loopback_indicator_o, // Loopback or user output one.
  output logic loopback_indicator_oe // Enable of that pin.
);
  import msp_pkg::*;

  logic [15:0] data_config_register_q;
  logic [15:0] data_config_register_two_q;
  logic [15:0] ctrl_q;
  logic dcr_written_q;
  logic was_master_q;
  logic extended_bus_setting;
  logic loop_en;
  logic [2:0] rxc_s_q, txc_s_q, rxd_s_q, line_s_q, osc_s_q, sync_cycle_termination_s_q;
  logic [2:0] ext_s_q, mode_s_q;
  logic rxc_lvl_q, txc_lvl_q, rxd_lvl_q, line_lvl_q, osc_lvl_q, sync_cycle_termination_lvl_q;
  logic ext_lvl_q, mode_lvl_q;
  logic sel_ext;
  logic osc_rise, ext_txc_rise, ext_rxc_rise, line_fall, line_edge;
  logic int_txc_q, int_rxc_q;
  logic tx_shift;
  logic [$clog2(CRS_HOLD_CYC+1)-1:0] crs_cnt_q;
  logic [$clog2(RXC_TAIL_CYC+1)-1:0] rxc_cnt_q;
  logic [$clog2(BIT_CYC)-1:0] rxc_div_q;
  logic crs_q, rxc_run;
  msp_tx_e tx_st_q;
  logic [7:0] sh_q;
  logic [2:0] bit_q;
  logic txd_q;
  logic f_valid, f_ready;
  logic [7:0] f_data;
  logic sync_cycle_termination_in;
  logic done_q;
  logic rx_bit_valid_q, rx_bit_q;
  logic [2:0] user_lvl;

  assign extended_bus_setting = data_config_register_q[DCR_EXTENDED_BUS_SETTING_BIT];
  assign loop_en = ctrl_q[CTRL_LBK_BIT];
  assign sel_ext = ext_lvl_q;
  assign user_lvl = data_config_register_two_q[2:0];

  // Register port.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      data_config_register_q <= DCR_RST;
      data_config_register_two_q <= DATA_CONFIG_REGISTER_TWO_RST;
      ctrl_q <= CTRL_RST;
      dcr_written_q <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_DCR) begin
        data_config_register_q <= reg_wdata;
        dcr_written_q <= 1'b1;
      end else if (reg_addr == ADDR_DATA_CONFIG_REGISTER_TWO) begin
        data_config_register_two_q <= reg_wdata;
      end else if (reg_addr == ADDR_CTRL) begin
        ctrl_q <= reg_wdata;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      if (reg_addr == ADDR_DCR) begin
        reg_rdata <= data_config_register_q;
      end else if (reg_addr == ADDR_DATA_CONFIG_REGISTER_TWO) begin
        reg_rdata <= data_config_register_two_q;
      end else if (reg_addr == ADDR_CTRL) begin
        reg_rdata <= ctrl_q;
      end else if (reg_addr == ADDR_STAT) begin
        reg_rdata <= {10'h000, was_master_q, dcr_written_q, crs_q, tx_active_flag, sel_ext, loop_en};
      end else begin
        reg_rdata <= 16'h0000;
      end
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // Mastership is latched once; user outputs drive from then on.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      was_master_q <= 1'b0;
    end else if (bus_master) begin
      was_master_q <= 1'b1;
    end
  end

  // Three-stage synchronisers; a change counts when stages two and three agree.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rxc_s_q <= 3'h0;
      txc_s_q <= 3'h0;
      rxd_s_q <= 3'h0;
      line_s_q <= 3'h7;
      osc_s_q <= 3'h0;
      sync_cycle_termination_s_q <= 3'h0;
      ext_s_q <= 3'h0;
      mode_s_q <= 3'h0;
    end else begin
      rxc_s_q <= {rxc_s_q[1:0], external_rx_clock_in};
      txc_s_q <= {txc_s_q[1:0], external_tx_clock_in};
      rxd_s_q <= {rxd_s_q[1:0], external_rx_bit_in};
      line_s_q <= {line_s_q[1:0], line_rx_in};
      osc_s_q <= {osc_s_q[1:0], osc_in};
      sync_cycle_termination_s_q <= {sync_cycle_termination_s_q[1:0], mem_cycle_end_req};
      ext_s_q <= {ext_s_q[1:0], external_coder_select};
      mode_s_q <= {mode_s_q[1:0], bus_mode_pin};
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rxc_lvl_q <= 1'b0;
      txc_lvl_q <= 1'b0;
      rxd_lvl_q <= 1'b0;
      line_lvl_q <= 1'b1;
      osc_lvl_q <= 1'b0;
      sync_cycle_termination_lvl_q <= 1'b0;
      ext_lvl_q <= 1'b0;
      mode_lvl_q <= 1'b0;
    end else begin
      if (rxc_s_q[1] == rxc_s_q[2]) rxc_lvl_q <= rxc_s_q[2];
      if (txc_s_q[1] == txc_s_q[2]) txc_lvl_q <= txc_s_q[2];
      if (rxd_s_q[1] == rxd_s_q[2]) rxd_lvl_q <= rxd_s_q[2];
      if (line_s_q[1] == line_s_q[2]) line_lvl_q <= line_s_q[2];
      if (osc_s_q[1] == osc_s_q[2]) osc_lvl_q <= osc_s_q[2];
      if (sync_cycle_termination_s_q[1] == sync_cycle_termination_s_q[2]) sync_cycle_termination_lvl_q <= sync_cycle_termination_s_q[2];
      if (ext_s_q[1] == ext_s_q[2]) ext_lvl_q <= ext_s_q[2];
      if (mode_s_q[1] == mode_s_q[2]) mode_lvl_q <= mode_s_q[2];
    end
  end

  assign osc_rise = !osc_lvl_q && (osc_s_q[1] == osc_s_q[2]) && osc_s_q[2];
  assign ext_txc_rise = !txc_lvl_q && (txc_s_q[1] == txc_s_q[2]) && txc_s_q[2];
  assign ext_rxc_rise = !rxc_lvl_q && (rxc_s_q[1] == rxc_s_q[2]) && rxc_s_q[2];
  assign line_edge = (line_s_q[1] == line_s_q[2]) && (line_s_q[2] != line_lvl_q);
  assign line_fall = line_edge && line_lvl_q;

  // Internal transmit clock: oscillator divided by two.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      int_txc_q <= 1'b0;
    end else if (osc_rise) begin
      int_txc_q <= !int_txc_q;
    end
  end

  // Serializer shifts on a rising external transmit clock, or on a falling internal one.
  assign tx_shift = sel_ext ? ext_txc_rise : (osc_rise && int_txc_q);

  // Internal decoder carrier sense with 1.5 bit hold.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      crs_q <= 1'b0;
      crs_cnt_q <= '0;
    end else if (line_fall || (crs_q && line_edge)) begin
      crs_q <= 1'b1;
      crs_cnt_q <= ($bits(crs_cnt_q))'(CRS_HOLD_CYC);
    end else if (crs_cnt_q != '0) begin
      crs_cnt_q <= crs_cnt_q - 1'b1;
    end else begin
      crs_q <= 1'b0;
    end
  end

  // Recovered clock runs while carrier is up and five bits after.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rxc_cnt_q <= '0;
    end else if (crs_q) begin
      rxc_cnt_q <= ($bits(rxc_cnt_q))'(RXC_TAIL_CYC);
    end else if (rxc_cnt_q != '0) begin
      rxc_cnt_q <= rxc_cnt_q - 1'b1;
    end
  end
  assign rxc_run = crs_q || (rxc_cnt_q != '0);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rxc_div_q <= '0;
      int_rxc_q <= 1'b0;
    end else if (rxc_run) begin
      if (line_edge && !crs_q) begin
        rxc_div_q <= '0;
      end else if (rxc_div_q == ($bits(rxc_div_q))'(BIT_CYC / 2 - 1)) begin
        rxc_div_q <= '0;
        int_rxc_q <= !int_rxc_q;
      end else begin
        rxc_div_q <= rxc_div_q + 1'b1;
      end
    end else begin
      rxc_div_q <= '0;
      int_rxc_q <= 1'b0;
    end
  end

  // Received bit to the MAC.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_bit_valid_q <= 1'b0;
      rx_bit_q <= 1'b0;
    end else if (sel_ext) begin
      rx_bit_valid_q <= ext_rxc_rise;
      if (ext_rxc_rise) rx_bit_q <= rxd_lvl_q;
    end else begin
      rx_bit_valid_q <= rxc_run && !int_rxc_q && (rxc_div_q == ($bits(rxc_div_q))'(BIT_CYC / 2 - 1));
      rx_bit_q <= line_lvl_q;
    end
  end
  assign rx_bit_valid = rx_bit_valid_q;
  assign rx_bit = rx_bit_q;
  assign carrier_sense_out = crs_q;

  msp_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data(tx_byte),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );
  assign f_ready = tx_shift && (tx_st_q == MSP_TX_IDLE || (tx_st_q != MSP_TX_IDLE && bit_q == 3'h7));

  // Serializer: bits change on each shift strobe and stand at the next rising transmit clock edge.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_st_q <= MSP_TX_IDLE;
      sh_q <= 8'h00;
      bit_q <= 3'h0;
      txd_q <= 1'b0;
    end else if (tx_shift) begin
      case (tx_st_q)
        MSP_TX_IDLE: begin
          txd_q <= 1'b0;
          if (f_valid) begin
            sh_q <= f_data >> 1;
            txd_q <= f_data[0];
            bit_q <= 3'h0;
            tx_st_q <= MSP_TX_SHIFT;
          end
        end
        MSP_TX_SHIFT: begin
          if (bit_q == 3'h7) begin
            bit_q <= 3'h0;
            if (f_valid) begin
              sh_q <= f_data >> 1;
              txd_q <= f_data[0];
            end else begin
              txd_q <= 1'b0;
              tx_st_q <= MSP_TX_IDLE;
            end
          end else begin
            txd_q <= sh_q[0];
            sh_q <= sh_q >> 1;
            bit_q <= bit_q + 1'b1;
          end
        end
        default: begin
          tx_st_q <= MSP_TX_IDLE;
        end
      endcase
    end
  end
  assign tx_active_flag = tx_st_q != MSP_TX_IDLE;

  // Sync termination is honoured only as master in asynchronous bus mode.
  assign sync_cycle_termination_in = sync_cycle_termination_lvl_q && bus_master && mode_lvl_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      done_q <= 1'b0;
    end else begin
      done_q <= sync_cycle_termination_in && !done_q;
    end
  end
  assign mem_cycle_done = done_q;

  // Pin multiplexing.
  always_comb begin
    rx_clk_o = 1'b0;
    rx_clk_oe = 1'b0;
    tx_data_o = 1'b0;
    tx_data_oe = 1'b0;
    loopback_indicator_o = 1'b0;
    loopback_indicator_oe = 1'b0;
    tx_clk_o = int_txc_q;
    tx_clk_oe = dcr_written_q && !sel_ext;
    if (!dcr_written_q) begin
      tx_clk_oe = 1'b0;
    end else if (extended_bus_setting) begin
      rx_clk_o = user_lvl[1];
      tx_data_o = user_lvl[2];
      loopback_indicator_o = user_lvl[0];
      rx_clk_oe = was_master_q;
      tx_data_oe = was_master_q;
      loopback_indicator_oe = was_master_q;
    end else begin
      rx_clk_o = int_rxc_q;
      rx_clk_oe = !sel_ext;
      tx_data_o = txd_q;
      tx_data_oe = 1'b1;
      loopback_indicator_o = loop_en;
      loopback_indicator_oe = 1'b1;
    end
  end
endmodule : msp_top
`default_nettype wire

// [verif/msp_chk_asserts.sv]
// Purpose: Port checker for msp_top.
// Assumes: 100 MHz clk_sys; outside pins pass three sync flops.
// Notes: Shadow bits follow register writes to predict pin levels.
`timescale 1ns/1ps
`default_nettype none
module msp_chk
  import msp_pkg::*;
(
  input wire logic clk_sys, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic [3:0] reg_addr, // Register address.
  input wire logic [15:0] reg_wdata, // Register write data.
  input wire logic reg_wr, // Write strobe.
  input wire logic external_coder_select, // Coder select pin.
  input wire logic bus_mode_pin, // Bus mode pin.
  input wire logic bus_master, // Bus ownership.
  input wire logic mem_cycle_end_req, // Termination request.
  input wire logic mem_cycle_done, // Termination pulse.
  input wire logic line_rx_in, // Receive line level.
  input wire logic carrier_sense_out, // Carrier sense.
  input wire logic tx_active_flag, // Transmit active flag.
  input wire logic tx_data_o, // Transmit data pin.
  input wire logic tx_data_oe, // Its enable.
  input wire logic rx_clk_o, // Receive clock pin.
  input wire logic rx_clk_oe, // Its enable.
  input wire logic tx_clk_o, // Transmit clock pin.
  input wire logic tx_clk_oe, // Its enable.
  input wire logic loopback_indicator_o, // Loopback pin.
  input wire logic loopback_indicator_oe // Its enable.
);
  logic dcr_q, exb_q, lbk_q, mst_q;
  logic [2:0] usr_q;
  logic [7:0] txe_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dcr_q <= 1'b0;
      exb_q <= 1'b0;
      lbk_q <= 1'b0;
      usr_q <= 3'h0;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_DCR) dcr_q <= 1'b1;
      if (reg_addr == ADDR_DCR) exb_q <= reg_wdata[DCR_EXTENDED_BUS_SETTING_BIT];
      if (reg_addr == ADDR_DATA_CONFIG_REGISTER_TWO) usr_q <= reg_wdata[2:0];
      if (reg_addr == ADDR_CTRL) lbk_q <= reg_wdata[CTRL_LBK_BIT];
    end
  end
  // Mastership is sticky; the flag run length saturates.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mst_q <= 1'b0;
      txe_q <= 8'h00;
    end else begin
      mst_q <= mst_q | bus_master;
      txe_q <= !tx_active_flag ? 8'h00 : (txe_q == 8'hff ? txe_q : txe_q + 8'h01);
    end
  end
  AST_FLOAT_RESET: assert property (!dcr_q |-> !(rx_clk_oe | tx_data_oe | tx_clk_oe | loopback_indicator_oe))
    else $error("pin driven before config write");
  AST_USER_FLOAT: assert property (dcr_q && exb_q && !mst_q |->
    !(rx_clk_oe | tx_data_oe | loopback_indicator_oe))
    else $error("user output driven before mastership");
  AST_USER_LEVEL: assert property (exb_q && $past(exb_q) && $past(mst_q, 2) |->
    rx_clk_oe && tx_data_oe && loopback_indicator_oe && {tx_data_o, rx_clk_o, loopback_indicator_o} == usr_q)
    else $error("user output level wrong");
  AST_LOOPBACK: assert property (dcr_q && !exb_q |->
    loopback_indicator_oe && tx_data_oe && loopback_indicator_o == lbk_q)
    else $error("loopback pin wrong");
  AST_RXC_INPUT: assert property ((external_coder_select [*6]) ##0 !exb_q |-> !rx_clk_oe)
    else $error("receive clock pin driven with external coder");
  AST_INT_CLOCKS: assert property ((!external_coder_select [*6]) ##0 (dcr_q && !exb_q) |->
    rx_clk_oe && tx_clk_oe)
    else $error("internal clock pins not driven");
  AST_TXC_RATE: assert property ($rose(tx_clk_o) |=> !$rose(tx_clk_o) [*8])
    else $error("transmit clock too fast");
  AST_CRS_RISE: assert property (!external_coder_select && $fell(line_rx_in) |-> ##[1:6] carrier_sense_out)
    else $error("carrier not raised");
  AST_RXC_TAIL: assert property (!exb_q && $fell(carrier_sense_out) |-> ##[30:45] $changed(rx_clk_o))
    else $error("receive clock stopped early");
  AST_SYNC_CYCLE_TERMINATION_ON: assert property ((bus_master && bus_mode_pin && mem_cycle_end_req) [*6] |->
    ##[0:1] mem_cycle_done)
    else $error("termination not honoured");
  AST_SYNC_CYCLE_TERMINATION_OFF: assert property ((!bus_mode_pin || !bus_master) [*6] |-> !mem_cycle_done)
    else $error("termination outside its mode");
  AST_TXE_SPAN: assert property ($fell(tx_active_flag) |-> txe_q >= 8'h46)
    else $error("transmit flag dropped early");
  cover property ($fell(tx_active_flag));
  cover property (mem_cycle_done);
  cover property ($fell(carrier_sense_out));
endmodule : msp_chk
bind msp_top msp_chk u_chk (.*);
`default_nettype wire

// [verif/msp_peer.sv]
// Purpose: Behavioural external coder facing msp_top.
// Assumes: Link clocks of 160 ns period.
// Notes: Transmit clock stands low while run is low.
`timescale 1ns/1ps
`default_nettype none
module msp_peer (
  input wire logic run, // Transmit clock enable.
  input wire logic tx_data_o, // Serial transmit data.
  input wire logic tx_active_flag, // Frame flag.
  output logic tx_clk, // Transmit clock.
  output logic rx_clk, // Receive clock.
  output logic rx_bit // Receive data.
);
  logic [15:0] got;
  int n_got;
  initial begin
    tx_clk = 1'b0;
    rx_clk = 1'b0;
    rx_bit = 1'b0;
    got = 16'h0000;
    n_got = 0;
  end
  always begin
    #80;
    tx_clk = run ? ~tx_clk : 1'b0;
  end
  // Bits are taken at the rising clock edge while the frame flag stands.
  always @(posedge tx_clk) begin
    if (tx_active_flag === 1'b1 && n_got < 16) begin
      got[n_got] = tx_data_o;
      n_got++;
    end
  end
  task automatic send(input logic [7:0] b);
    #3;
    for (int i = 0; i < 8; i++) begin
      rx_bit = b[i];
      #80 rx_clk = 1'b1;
      #80 rx_clk = 1'b0;
    end
    rx_bit = ~b[7];
  endtask : send
endmodule : msp_peer
`default_nettype wire

// [verif/testbench.sv]
// Purpose: Self-checking bench for msp_top.
// Assumes: 100 MHz clk_sys, 20 MHz oscillator, 160 ns link clocks.
// Notes: Enables pack as rx clock, tx data, tx clock, loopback.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import msp_pkg::*;
  logic clk_sys, rst_n, reg_wr, reg_rd, osc_in, line_rx_in, external_coder_select;
  logic bus_mode_pin, bus_master, mem_cycle_end_req, tx_valid, run, txc_p, rxc_p;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic [7:0] tx_byte, rx_w;
  logic tx_ready, mem_cycle_done, rx_bit_valid, rx_bit, carrier_sense_out, tx_active_flag;
  logic tx_data_o, tx_data_oe, rx_clk_o, rx_clk_oe, tx_clk_o, tx_clk_oe;
  logic loopback_indicator_o, loopback_indicator_oe;
  wire logic external_tx_clock_in, external_rx_clock_in, external_rx_bit_in;
  wire logic [3:0] oe_v = {rx_clk_oe, tx_data_oe, tx_clk_oe, loopback_indicator_oe};
  wire logic [2:0] val_v = {tx_data_o, rx_clk_o, loopback_indicator_o};
  int n_fail = 0, checks = 0, n_txc = 0, n_rxc = 0, n_done = 0, n_rx = 0, a, k;
  msp_top dut (.*);
  msp_peer u_peer (.run(run), .tx_data_o(tx_data_o), .tx_active_flag(tx_active_flag),
    .tx_clk(external_tx_clock_in), .rx_clk(external_rx_clock_in), .rx_bit(external_rx_bit_in));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic wr(input logic [3:0] a_i, input logic [15:0] d_i);
    @(posedge clk_sys);
    reg_addr <= a_i;
    reg_wdata <= d_i;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a_i, output logic [15:0] d_o);
    @(posedge clk_sys);
    reg_addr <= a_i;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d_o = reg_rdata;
  endtask : rd
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    osc_in = 1'b0;
    #2;
    forever #25 osc_in = ~osc_in;
  end
  initial begin
    #100000;
    n_fail++;
    close_out();
  end
  always @(posedge clk_sys) begin
    txc_p <= tx_clk_o;
    rxc_p <= rx_clk_o;
    if (tx_clk_o && !txc_p) n_txc++;
    if (rx_clk_o !== rxc_p) n_rxc++;
    if (mem_cycle_done) n_done++;
    if (rx_bit_valid) n_rx++;
    if (rx_bit_valid) rx_w <= {rx_bit, rx_w[7:1]};
  end
  initial begin
    {rst_n, reg_wr, reg_rd, external_coder_select, bus_mode_pin, bus_master} = 6'h00;
    {mem_cycle_end_req, tx_valid, run} = 3'h0;
    line_rx_in = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    tx_byte = 8'h00;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    tick(4);
    chk({12'h000, oe_v}, 16'h0000);
    rd(ADDR_DCR, d);
    chk(d, DCR_RST);
    wr(ADDR_CTRL, 16'h0001);
    tick(1);
    chk({12'h000, oe_v}, 16'h0000);
    wr(ADDR_DCR, 16'h0000);
    tick(1);
    chk({12'h000, oe_v}, 16'h000f);
    chk({15'h0000, loopback_indicator_o}, 16'h0001);
    wr(ADDR_CTRL, 16'h0000);
    tick(1);
    chk({15'h0000, loopback_indicator_o}, 16'h0000);
    rd(4'hf, d);
    chk(d, 16'h0000);
    a = n_txc;
    tick(100);
    chk(16'(n_txc - a), 16'h000a);
    @(posedge clk_sys);
    line_rx_in <= 1'b0;
    tick(6);
    chk({15'h0000, carrier_sense_out}, 16'h0001);
    repeat (15) begin
      @(posedge clk_sys);
      line_rx_in <= ~line_rx_in;
      tick(4);
    end
    for (k = 0; k < 100 && carrier_sense_out === 1'b1; k++) tick(1);
    chk({15'h0000, k >= 12}, 16'h0001);
    a = n_rxc;
    tick(40);
    chk({15'h0000, n_rxc - a >= 7}, 16'h0001);
    @(posedge clk_sys);
    external_coder_select <= 1'b1;
    tick(8);
    chk({12'h000, oe_v}, 16'h0005);
    for (k = 0; k < 8; k++) begin
      @(posedge clk_sys);
      tx_byte <= 8'(k * 16 + 15 - k);
      tx_valid <= 1'b1;
    end
    @(posedge clk_sys);
    tx_valid <= 1'b0;
    #1;
    chk({15'h0000, tx_ready}, 16'h0000);
    @(posedge clk_sys);
    run <= 1'b1;
    for (k = 0; k < 200 && tx_active_flag !== 1'b1; k++) tick(1);
    for (k = 0; k < 2000 && tx_active_flag !== 1'b0; k++) tick(1);
    chk({14'h0000, k > 1000, k < 1100}, 16'h0003);
    chk(u_peer.got, 16'h1e0f);
    chk({15'h0000, tx_ready}, 16'h0001);
    run <= 1'b0;
    a = n_rx;
    u_peer.send(8'h96);
    tick(8);
    chk({8'h00, rx_w}, 16'h0096);
    chk(16'(n_rx - a), 16'h0008);
    wr(ADDR_DCR, 16'h0001);
    wr(ADDR_DATA_CONFIG_REGISTER_TWO, 16'h0005);
    tick(1);
    chk({12'h000, oe_v}, 16'h0000);
    @(posedge clk_sys);
    bus_master <= 1'b1;
    mem_cycle_end_req <= 1'b1;
    a = n_done;
    tick(20);
    chk(16'(n_done - a), 16'h0000);
    chk({12'h000, oe_v}, 16'h000d);
    chk({13'h0000, val_v}, 16'h0005);
    wr(ADDR_DATA_CONFIG_REGISTER_TWO, 16'h0002);
    tick(1);
    chk({13'h0000, val_v}, 16'h0002);
    @(posedge clk_sys);
    bus_mode_pin <= 1'b1;
    a = n_done;
    tick(20);
    chk({15'h0000, n_done > a}, 16'h0001);
    rd(ADDR_DATA_CONFIG_REGISTER_TWO, d);
    chk(d, 16'h0002);
    rd(ADDR_STAT, d);
    chk(d, 16'h0032);
    close_out();
  end
endmodule : testbench
`default_nettype wire
